/* rtl/audio_dma_pkg.sv */
// Register map, field positions, reset values and types of the audio DMA slice.
// Assumes byte addresses on a 32-bit register port, one word per register.
package audio_dma_pkg;

  // Register byte addresses
  localparam logic [31:0] REC_BASE_OFS    = 32'hFFF0_9008;
  localparam logic [31:0] REC_LENGTH_OFS  = 32'hFFF0_900C;
  localparam logic [31:0] REC_CUR_OFS     = 32'hFFF0_9010;
  localparam logic [31:0] REC_STATUS_OFS  = 32'hFFF0_9014;
  localparam logic [31:0] PLAY_BASE_OFS   = 32'hFFF0_9018;
  localparam logic [31:0] PLAY_LENGTH_OFS = 32'hFFF0_901C;
  localparam logic [31:0] PLAY_CUR_OFS    = 32'hFFF0_9020;
  localparam logic [31:0] PLAY_STATUS_OFS = 32'hFFF0_9024;
  localparam logic [31:0] DMA_CTRL_OFS    = 32'hFFF0_9040;
  localparam logic [31:0] INT_STATUS_OFS  = 32'hFFF0_9044;
  localparam logic [31:0] INT_MASK_OFS    = 32'hFFF0_9048;

  // Status register fields
  localparam int MIDDLE_IRQ_BIT = 0;
  localparam int END_IRQ_BIT    = 1;
  localparam int FIFO_FLAG_BIT  = 2;

  // Control register fields
  localparam int REC_RUN_BIT  = 0;
  localparam int PLAY_RUN_BIT = 1;

  // Interrupt status and mask fields
  localparam int INT_REC_MID_BIT   = 0;
  localparam int INT_REC_END_BIT   = 1;
  localparam int INT_PLAY_MID_BIT  = 2;
  localparam int INT_PLAY_END_BIT  = 3;
  localparam int INT_WIDTH         = 4;

  // Reset values
  localparam logic [31:0] REC_STATUS_RST  = 32'h0000_0000;
  localparam logic [31:0] PLAY_STATUS_RST = 32'h0000_0004;
  localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [3:0]  MASK_RST        = 4'h0;

  // One memory beat moves one 32-bit word
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_LOAD = 2'b01,
    CH_RUN  = 2'b11
  } chan_state_t;

endpackage : audio_dma_pkg

/* rtl/dma_chan_if.sv */
// Carrier between the register file and one DMA address channel.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface dma_chan_if;
  logic [31:0] base;
  logic [31:0] length;
  logic        run;
  logic [31:0] cur;
  logic        midEvt;
  logic        endEvt;

  modport ctrl (output base, output length, output run,
                input cur, input midEvt, input endEvt);
  modport chan (input base, input length, input run,
                output cur, output midEvt, output endEvt);
endinterface : dma_chan_if

/* rtl/sticky_flag.sv */
// Group of sticky event flags, cleared by writing one.
// Assumes set and clear are single-cycle pulses in the clk domain.
`timescale 1ns/100ps
module sticky_flag #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Events and clears
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // Flags
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] next_q;

  // A set in the clearing cycle wins so no event is lost
  always_comb begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : sticky_flag

/* rtl/dma_channel.sv */
// One DMA address walker: steps from base to base plus length, word by word.
// Assumes the memory side acknowledges a request with a one-cycle memAck.
`timescale 1ns/100ps
module dma_channel (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register side
  dma_chan_if.chan         bus,
  // FIFO side
  input  wire logic        fifoReady,
  // Memory side
  output logic             memReq,
  output logic      [31:0] memAddr,
  input  wire logic        memAck
);
  audio_dma_pkg::chan_state_t state;
  audio_dma_pkg::chan_state_t next_state;
  logic [31:0] cur;
  logic [31:0] next_cur;
  logic        next_midEvt;
  logic        next_endEvt;
  logic        midEvt;
  logic        endEvt;
  logic [31:0] stepAddr;
  logic [31:0] midAddr;
  logic [31:0] endAddr;

  assign midAddr  = bus.base + {1'b0, bus.length[31:1]};
  assign endAddr  = bus.base + bus.length;
  assign stepAddr = cur + audio_dma_pkg::WORD_STEP;
  // A zero length would never reach its end, so it never requests; a cleared run bit
  // drops the request at once so a beat acknowledged while stopping is never lost
  assign memReq   = (state == audio_dma_pkg::CH_RUN) && bus.run && fifoReady
                    && (bus.length != '0);
  assign memAddr  = cur;
  assign bus.cur    = cur;
  assign bus.midEvt = midEvt;
  assign bus.endEvt = endEvt;

  always_comb begin
    next_state  = state;
    next_cur    = cur;
    next_midEvt = 1'b0;
    next_endEvt = 1'b0;
    case (state)
      audio_dma_pkg::CH_IDLE: begin
        if (bus.run) begin
          next_state = audio_dma_pkg::CH_LOAD;
        end
      end
      audio_dma_pkg::CH_LOAD: begin
        next_cur   = bus.base;
        next_state = bus.run ? audio_dma_pkg::CH_RUN : audio_dma_pkg::CH_IDLE;
      end
      audio_dma_pkg::CH_RUN: begin
        if (!bus.run) begin
          next_state = audio_dma_pkg::CH_IDLE;
        end else if (memReq && memAck) begin
          if (stepAddr == endAddr) begin
            next_endEvt = 1'b1;
            next_cur    = bus.base;
          end else begin
            next_midEvt = (stepAddr == midAddr);
            next_cur    = stepAddr;
          end
        end
      end
      default: begin
        next_state = audio_dma_pkg::CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= audio_dma_pkg::CH_IDLE;
      cur    <= audio_dma_pkg::ADDR_RST;
      midEvt <= 1'b0;
      endEvt <= 1'b0;
    end else begin
      state  <= next_state;
      cur    <= next_cur;
      midEvt <= next_midEvt;
      endEvt <= next_endEvt;
    end
  end
endmodule : dma_channel

/* rtl/audio_dma_regs.sv */
// Audio DMA status and address registers with record and playback walkers.
// Assumes a one-cycle register port with read data the cycle after the read strobe.
// Summary of operation
// - Record status bit 2 reads one while the record FIFO is full.
// - Record end flag sets when the address reaches end; write one clears.
// - Record middle flag sets at the middle address; write one clears it.
// - Record status resets to zero; bits 31 to 3 read zero.
// - Playback base address is CPU read/write, reset zero.
// - Playback length is CPU read/write, reset zero.
// - Playback current address is read-only, advanced by the DMA.
// - Playback status bit 2 shows FIFO empty; register resets to 4.
// - Playback end flag sets at end address; cleared by writing one.
// - Playback middle flag sets at middle address; cleared by writing one.
// - Record side has its own base, length and read-only current address.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module audio_dma_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Record memory side
  output logic             recMemReq,
  output logic      [31:0] recMemAddr,
  input  wire logic        recMemAck,
  // Record FIFO status
  input  wire logic        recDataAvail,
  input  wire logic        recFifoFull,
  // Playback memory side
  output logic             playMemReq,
  output logic      [31:0] playMemAddr,
  input  wire logic        playMemAck,
  // Playback FIFO status
  input  wire logic        playSpaceAvail,
  input  wire logic        playFifoEmpty,
  // Interrupt
  output logic             irq
);
  dma_chan_if recBus ();
  dma_chan_if playBus ();

  logic [31:0] recBase;
  logic [31:0] recLength;
  logic [31:0] playBase;
  logic [31:0] playLength;
  logic [31:0] ctrl;
  logic [3:0]  intMask;
  logic [31:0] next_recBase;
  logic [31:0] next_recLength;
  logic [31:0] next_playBase;
  logic [31:0] next_playLength;
  logic [31:0] next_ctrl;
  logic [3:0]  next_intMask;
  logic [31:0] next_regRdata;
  logic        playEmptyFlag;
  logic [1:0]  recFlags;
  logic [1:0]  playFlags;
  logic [1:0]  recClr;
  logic [1:0]  playClr;
  logic [3:0]  intStatus;
  logic        wrRecStatus;
  logic        wrPlayStatus;
  logic        wrIntStatus;

  assign recBus.base     = recBase;
  assign recBus.length   = recLength;
  assign recBus.run      = ctrl[audio_dma_pkg::REC_RUN_BIT];
  assign playBus.base    = playBase;
  assign playBus.length  = playLength;
  assign playBus.run     = ctrl[audio_dma_pkg::PLAY_RUN_BIT];

  dma_channel recChan (
    .clk       (clk),
    .rst_n     (rst_n),
    .bus       (recBus.chan),
    .fifoReady (recDataAvail),
    .memReq    (recMemReq),
    .memAddr   (recMemAddr),
    .memAck    (recMemAck)
  );

  dma_channel playChan (
    .clk       (clk),
    .rst_n     (rst_n),
    .bus       (playBus.chan),
    .fifoReady (playSpaceAvail),
    .memReq    (playMemReq),
    .memAddr   (playMemAddr),
    .memAck    (playMemAck)
  );

  // Write-one-to-clear decode; either status alias clears the same flag
  assign wrRecStatus  = regWrite && (regAddr == audio_dma_pkg::REC_STATUS_OFS);
  assign wrPlayStatus = regWrite && (regAddr == audio_dma_pkg::PLAY_STATUS_OFS);
  assign wrIntStatus  = regWrite && (regAddr == audio_dma_pkg::INT_STATUS_OFS);

  always_comb begin
    recClr  = 2'h0;
    playClr = 2'h0;
    if (wrRecStatus) begin
      recClr[audio_dma_pkg::MIDDLE_IRQ_BIT] = regWdata[audio_dma_pkg::MIDDLE_IRQ_BIT];
      recClr[audio_dma_pkg::END_IRQ_BIT]    = regWdata[audio_dma_pkg::END_IRQ_BIT];
    end
    if (wrPlayStatus) begin
      playClr[audio_dma_pkg::MIDDLE_IRQ_BIT] = regWdata[audio_dma_pkg::MIDDLE_IRQ_BIT];
      playClr[audio_dma_pkg::END_IRQ_BIT]    = regWdata[audio_dma_pkg::END_IRQ_BIT];
    end
    if (wrIntStatus) begin
      recClr[audio_dma_pkg::MIDDLE_IRQ_BIT]  = recClr[audio_dma_pkg::MIDDLE_IRQ_BIT]
                                            | regWdata[audio_dma_pkg::INT_REC_MID_BIT];
      recClr[audio_dma_pkg::END_IRQ_BIT]     = recClr[audio_dma_pkg::END_IRQ_BIT]
                                            | regWdata[audio_dma_pkg::INT_REC_END_BIT];
      playClr[audio_dma_pkg::MIDDLE_IRQ_BIT] = playClr[audio_dma_pkg::MIDDLE_IRQ_BIT]
                                            | regWdata[audio_dma_pkg::INT_PLAY_MID_BIT];
      playClr[audio_dma_pkg::END_IRQ_BIT]    = playClr[audio_dma_pkg::END_IRQ_BIT]
                                            | regWdata[audio_dma_pkg::INT_PLAY_END_BIT];
    end
  end

  sticky_flag #(.WIDTH(2)) recFlagReg (
    .clk   (clk),
    .rst_n (rst_n),
    .set   ({recBus.endEvt, recBus.midEvt}),
    .clr   (recClr),
    .q     (recFlags)
  );

  sticky_flag #(.WIDTH(2)) playFlagReg (
    .clk   (clk),
    .rst_n (rst_n),
    .set   ({playBus.endEvt, playBus.midEvt}),
    .clr   (playClr),
    .q     (playFlags)
  );

  assign intStatus = {playFlags[audio_dma_pkg::END_IRQ_BIT],
                      playFlags[audio_dma_pkg::MIDDLE_IRQ_BIT],
                      recFlags[audio_dma_pkg::END_IRQ_BIT],
                      recFlags[audio_dma_pkg::MIDDLE_IRQ_BIT]};
  // Level output; a flag left pending hides a second pass of the same point
  assign irq = |(intStatus & intMask);

  always_comb begin
    next_recBase    = recBase;
    next_recLength  = recLength;
    next_playBase   = playBase;
    next_playLength = playLength;
    next_ctrl       = ctrl;
    next_intMask    = intMask;
    if (regWrite) begin
      case (regAddr)
        audio_dma_pkg::REC_BASE_OFS:    next_recBase    = regWdata;
        audio_dma_pkg::REC_LENGTH_OFS:  next_recLength  = regWdata;
        audio_dma_pkg::PLAY_BASE_OFS:   next_playBase   = regWdata;
        audio_dma_pkg::PLAY_LENGTH_OFS: next_playLength = regWdata;
        audio_dma_pkg::DMA_CTRL_OFS:    next_ctrl       = {30'h0, regWdata[1:0]};
        audio_dma_pkg::INT_MASK_OFS:    next_intMask    = regWdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // The FIFO flag bits pass through unregistered; only the read data register samples them
  assign playEmptyFlag = playFifoEmpty;

  always_comb begin
    next_regRdata = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        audio_dma_pkg::REC_BASE_OFS:    next_regRdata = recBase;
        audio_dma_pkg::REC_LENGTH_OFS:  next_regRdata = recLength;
        audio_dma_pkg::REC_CUR_OFS:     next_regRdata = recBus.cur;
        audio_dma_pkg::REC_STATUS_OFS: begin
          next_regRdata = audio_dma_pkg::REC_STATUS_RST;
          next_regRdata[audio_dma_pkg::FIFO_FLAG_BIT] = recFifoFull;
          next_regRdata[audio_dma_pkg::END_IRQ_BIT]   = recFlags[audio_dma_pkg::END_IRQ_BIT];
          next_regRdata[audio_dma_pkg::MIDDLE_IRQ_BIT] =
            recFlags[audio_dma_pkg::MIDDLE_IRQ_BIT];
        end
        audio_dma_pkg::PLAY_BASE_OFS:   next_regRdata = playBase;
        audio_dma_pkg::PLAY_LENGTH_OFS: next_regRdata = playLength;
        audio_dma_pkg::PLAY_CUR_OFS:    next_regRdata = playBus.cur;
        audio_dma_pkg::PLAY_STATUS_OFS: begin
          next_regRdata = 32'h0000_0000;
          next_regRdata[audio_dma_pkg::FIFO_FLAG_BIT] = playEmptyFlag;
          next_regRdata[audio_dma_pkg::END_IRQ_BIT]   = playFlags[audio_dma_pkg::END_IRQ_BIT];
          next_regRdata[audio_dma_pkg::MIDDLE_IRQ_BIT] =
            playFlags[audio_dma_pkg::MIDDLE_IRQ_BIT];
        end
        audio_dma_pkg::DMA_CTRL_OFS:    next_regRdata = ctrl;
        audio_dma_pkg::INT_STATUS_OFS:  next_regRdata = {28'h0, intStatus};
        audio_dma_pkg::INT_MASK_OFS:    next_regRdata = {28'h0, intMask};
        default:                        next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recBase    <= audio_dma_pkg::ADDR_RST;
      recLength  <= audio_dma_pkg::ADDR_RST;
      playBase   <= audio_dma_pkg::ADDR_RST;
      playLength <= audio_dma_pkg::ADDR_RST;
      ctrl       <= audio_dma_pkg::CTRL_RST;
      intMask    <= audio_dma_pkg::MASK_RST;
      regRdata   <= 32'h0000_0000;
    end else begin
      recBase    <= next_recBase;
      recLength  <= next_recLength;
      playBase   <= next_playBase;
      playLength <= next_playLength;
      ctrl       <= next_ctrl;
      intMask    <= next_intMask;
      regRdata   <= next_regRdata;
    end
  end
endmodule : audio_dma_regs

/* tb/audio_dma_regs_properties.sv */
// Port-level assertions for the audio DMA register block.
// Assumes it is bound onto audio_dma_regs; one clock domain.
`timescale 1ns/100ps
module audio_dma_regs_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  // DMA and FIFO sides
  input wire logic [31:0] recMemAddr,
  input wire logic        recFifoFull,
  input wire logic        playMemReq,
  input wire logic [31:0] playMemAddr,
  input wire logic        playMemAck,
  input wire logic        playFifoEmpty
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rdata_idle;
    !regRead |=> regRdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_rec_full;
    regRead && regAddr == audio_dma_pkg::REC_STATUS_OFS |=> regRdata[2] == $past(recFifoFull);
  endproperty
  a_rec_full: assert property (p_rec_full) else $error("record full bit wrong");
  property p_rec_rsvd;
    regRead && regAddr == audio_dma_pkg::REC_STATUS_OFS |=> regRdata[31:3] == 29'h0;
  endproperty
  a_rec_rsvd: assert property (p_rec_rsvd) else $error("record reserved bits set");
  property p_play_empty;
    regRead && regAddr == audio_dma_pkg::PLAY_STATUS_OFS
      |=> regRdata[31:2] == {29'h0, $past(playFifoEmpty)};
  endproperty
  a_play_empty: assert property (p_play_empty) else $error("playback empty bit wrong");
  property p_play_cur;
    regRead && regAddr == audio_dma_pkg::PLAY_CUR_OFS |=> regRdata == $past(playMemAddr);
  endproperty
  a_play_cur: assert property (p_play_cur) else $error("playback current differs");
  property p_rec_cur;
    regRead && regAddr == audio_dma_pkg::REC_CUR_OFS |=> regRdata == $past(recMemAddr);
  endproperty
  a_rec_cur: assert property (p_rec_cur) else $error("record current differs");
  // A wrap lands below the old address, so either a word step or a drop is legal
  property p_play_step;
    playMemReq && playMemAck |=> playMemAddr == $past(playMemAddr) + audio_dma_pkg::WORD_STEP
      || playMemAddr < $past(playMemAddr);
  endproperty
  a_play_step: assert property (p_play_step) else $error("playback step wrong");
  property p_play_stop;
    regWrite && regAddr == audio_dma_pkg::DMA_CTRL_OFS && !regWdata[1] |=> !playMemReq [*3];
  endproperty
  a_play_stop: assert property (p_play_stop) else $error("playback request after stop");
endmodule : audio_dma_regs_properties

bind audio_dma_regs audio_dma_regs_properties audio_dma_regs_properties_i (.clk, .rst_n,
  .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .recMemAddr, .recFifoFull,
  .playMemReq, .playMemAddr, .playMemAck, .playFifoEmpty);

/* tb/mem_responder.sv */
// Memory side of one DMA channel: takes each request after a programmable wait.
// Assumes the request is a level in the clk domain.
`timescale 1ns/100ps
module mem_responder (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request and answer
  input  wire logic       req,
  input  wire logic [3:0] waitCycles,
  output logic            ack
);
  logic [3:0] cnt;
  // Ack only beside a live request, so a stalled channel never sees a stray beat
  assign ack = req && (cnt >= waitCycles);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 4'h0;
    else cnt <= (req && !ack) ? cnt + 4'h1 : 4'h0;
  end
endmodule : mem_responder

/* tb/audio_dma_regs_tb_top.sv */
// Self-checking bench for the audio DMA register block against an array-based model.
// Assumes the package register map and a 25 MHz clock.
`timescale 1ns/100ps
module audio_dma_regs_tb_top;
  logic        clk;
  logic        rst_n;
  logic [31:0] regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic [1:0]  req;
  logic [1:0]  ack;
  logic [31:0] recMemAddr;
  logic [31:0] playMemAddr;
  logic        recDataAvail;
  logic        recFifoFull;
  logic        playSpaceAvail;
  logic        playFifoEmpty;
  logic        irq;
  logic        hold;
  logic [3:0]  waitCycles;
  logic [31:0] m [12];
  logic [1:0]  mFlg [2];
  logic [31:0] addrs [$];
  int          bad_count;
  int          num_checks;

  audio_dma_regs audio_dma_regs_i (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .recMemReq(req[0]), .recMemAddr, .recMemAck(ack[0]), .recDataAvail,
    .recFifoFull, .playMemReq(req[1]), .playMemAddr, .playMemAck(ack[1]), .playSpaceAvail,
    .playFifoEmpty, .irq);
  mem_responder mem_responder_i [1:0] (.clk, .rst_n, .req, .waitCycles, .ack);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Random stalls on both FIFO sides; hold parks both channels before a stop
  always @(posedge clk) begin
    recDataAvail   <= !hold && ($urandom % 4 != 0);
    playSpaceAvail <= !hold && ($urandom % 4 != 0);
  end

  // Model walker: channel c keeps base, length, current at m[4c], m[4c+1], m[4c+2]
  always @(posedge clk)
    for (int c = 0; c < 2; c++)
      if (rst_n && req[c] && ack[c]) begin
        chk(c ? playMemAddr : recMemAddr, m[4*c+2]);
        m[4*c+2] = m[4*c+2] + 32'h0000_0004;
        if (m[4*c+2] == m[4*c] + m[4*c+1]) begin
          m[4*c+2] = m[4*c];
          mFlg[c][1] = 1'b1;
        end else if (m[4*c+2] == m[4*c] + (m[4*c+1] >> 1)) mFlg[c][0] = 1'b1;
      end

  function automatic logic [31:0] expv(int i);
    case (i)
      3:       return {29'h0, recFifoFull, mFlg[0]};
      7:       return {29'h0, playFifoEmpty, mFlg[1]};
      9:       return {28'h0, mFlg[1], mFlg[0]};
      11:      return 32'h0000_0000;
      default: return m[i];
    endcase
  endfunction : expv

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(int i, logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= addrs[i];
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    case (i)
      0, 1, 4, 5: m[i] = d;
      3:  mFlg[0] &= ~d[1:0];
      7:  mFlg[1] &= ~d[1:0];
      9:  {mFlg[1], mFlg[0]} = {mFlg[1], mFlg[0]} & ~d[3:0];
      10: m[10] = {28'h0, d[3:0]};
      8: begin
        if (d[0] && !m[8][0]) m[2] = m[0];
        if (d[1] && !m[8][1]) m[6] = m[4];
        m[8] = {30'h0, d[1:0]};
      end
      default: ;
    endcase
  endtask : wr

  task automatic rc(int i);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= addrs[i];
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRdata, expv(i));
  endtask : rc

  task automatic ci;
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, |({mFlg[1], mFlg[0]} & m[10][3:0])});
  endtask : ci

  task automatic tally_and_finish;
    $display("Comparisons: %0d, mismatches: %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Whole run needs well under two thousand cycles; twenty thousand leaves ample margin
  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    addrs = {audio_dma_pkg::REC_BASE_OFS, audio_dma_pkg::REC_LENGTH_OFS,
             audio_dma_pkg::REC_CUR_OFS, audio_dma_pkg::REC_STATUS_OFS,
             audio_dma_pkg::PLAY_BASE_OFS, audio_dma_pkg::PLAY_LENGTH_OFS,
             audio_dma_pkg::PLAY_CUR_OFS, audio_dma_pkg::PLAY_STATUS_OFS,
             audio_dma_pkg::DMA_CTRL_OFS, audio_dma_pkg::INT_STATUS_OFS,
             audio_dma_pkg::INT_MASK_OFS, 32'hFFF0_9030};
    m = '{default: 32'h0000_0000};
    mFlg = '{default: 2'h0};
    {rst_n, regWrite, regRead, hold, recFifoFull, recDataAvail, playSpaceAvail} = 7'h00;
    regAddr = 32'h0000_0000;
    regWdata = 32'h0000_0000;
    playFifoEmpty = 1'b1;
    waitCycles = 4'h0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(52));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (addrs[i]) rc(i);
    @(posedge clk);
    recFifoFull   <= 1'b1;
    playFifoEmpty <= 1'b0;
    // Current-address writes must be ignored
    for (int i = 0; i < 8; i++) if (i % 4 < 3) wr(i, $urandom);
    foreach (addrs[i]) rc(i);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      waitCycles <= r ? 4'h0 : 4'h3;
      hold <= 1'b0;
      wr(0, 32'h0000_1000);
      wr(1, 32'h0000_0010);
      wr(4, $urandom & 32'h00FF_FFF0);
      wr(5, 32'h0000_0020);
      wr(8, 32'h0000_0003);
      for (int t = 0; t < 600 && !(mFlg[0][1] && mFlg[1][1]); t++) @(posedge clk);
      chk({31'h0, mFlg[0][1] && mFlg[1][1]}, 32'h0000_0001);
      hold <= 1'b1;
      repeat (3) @(posedge clk);
      wr(8, 32'h0000_0000);
      repeat (3) @(posedge clk);
      foreach (addrs[i]) rc(i);
      wr(10, 32'h0000_0000);
      ci();
      wr(10, 32'h0000_000C);
      ci();
      wr(7, 32'h0000_0001);
      wr(3, 32'hFFFF_FFFC);
      rc(3);
      rc(7);
      ci();
      wr(9, 32'h0000_000F);
      rc(9);
      ci();
    end
    tally_and_finish();
  end
endmodule : audio_dma_regs_tb_top
